// file: core/bsil_core.sv
// boundary cell chain, control register and run-test operations
// assumes tap state strobes and ir come from a tap controller on core_clk
`timescale 1ns/1ns
`include "bsil_defs.svh"

module bsil_core #(
  parameter logic [15:0] TAPS16 = `BSIL_TAPS16,
  parameter logic [7:0]  TAPS8  = `BSIL_TAPS8
) (
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  input  wire logic [7:0]              ir_value,
  input  wire bsil_pkg::bsil_tap_type  tap,
  input  wire logic                    tdi,
  input  wire bsil_pkg::bsil_pins_type pins,
  input  wire logic [7:0]              core_q,
  output logic                         tdo_bit,
  output logic [7:0]                   q_pin_out,
  output logic [7:0]                   q_pin_oe,
  output logic [7:0]                   core_d,
  output logic                         core_le,
  output logic                         core_oe_n,
  output logic                         test_mode,
  output logic [1:0]                   bcr_value
);

  // one lfsr step; zero in gives zero out
  function automatic logic [15:0] step16(input logic [15:0] v);
    step16 = {v[14:0], ^(v & TAPS16)};
  endfunction

  function automatic logic [7:0] step8(input logic [7:0] v);
    step8 = {v[6:0], ^(v & TAPS8)};
  endfunction

  bsil_pkg::bsil_dec_type dec;

  // decode is pure logic, no state of its own
  bsil_decode u_dec (
    .ir  (ir_value),
    .dec (dec)
  );

  // pin synchronisers
  bsil_pkg::bsil_pins_type pin_s1_r;
  bsil_pkg::bsil_pins_type pin_s1_nxt;
  bsil_pkg::bsil_pins_type pin_s2_r;
  bsil_pkg::bsil_pins_type pin_s2_nxt;

  always_comb
  begin
    pin_s1_nxt = pins;
    pin_s2_nxt = pin_s1_r;
  end

  always_ff @(posedge core_clk)
  begin
    // idle levels: output enable inactive, so pins stay floated after reset except in test mode, where shadow bit 16 drives them
    if (!nrst)
    begin
      pin_s1_r <= `BSIL_PIN_IDLE;
      pin_s2_r <= `BSIL_PIN_IDLE;
    end
    else
    begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
    end
  end

  // scan registers
  logic [17:0] chain_r;
  logic [17:0] chain_nxt;
  logic [17:0] shadow_r;
  logic [17:0] shadow_nxt;
  logic [17:0] upd_mask_r;
  logic [17:0] upd_mask_nxt;
  logic [1:0]  bcr_shift_r;
  logic [1:0]  bcr_shift_nxt;
  logic [1:0]  boundary_control_reg_r;
  logic [1:0]  boundary_control_reg_nxt;
  logic        bypass_r;
  logic        bypass_nxt;

  logic        run_test_instruction_active;
  logic        toggle_active;
  logic [7:0]  din;
  logic [15:0] sig16;

  always_comb
  begin
    chain_nxt                = chain_r;
    shadow_nxt               = shadow_r;
    upd_mask_nxt             = '0;
    bcr_shift_nxt            = bcr_shift_r;
    boundary_control_reg_nxt = boundary_control_reg_r;
    bypass_nxt               = bypass_r;
    din                      = pin_s2_r.data_pin;
    run_test_instruction_active   = tap.run_idle && (dec.instr == bsil_pkg::BSIL_I_RUN_TEST_INSTRUCTION);
    toggle_active = tap.run_idle && (dec.instr == bsil_pkg::BSIL_I_TOGGLE);
    sig16         = step16(chain_r[15:0]) ^ {din, 8'h00};

    // shadow update one cycle after a run step
    shadow_nxt = (shadow_r & ~upd_mask_r) | (chain_r & upd_mask_r);

    if (tap.tlr)
    begin
      boundary_control_reg_nxt = `BSIL_BCR_RST;
    end
    else if (tap.capture_dr)
    begin
      unique case (dec.path)
        bsil_pkg::BSIL_P_CHAIN:
        begin
          if (dec.instr == bsil_pkg::BSIL_I_CELLT)
            chain_nxt = ~shadow_r;
          else if (dec.instr != bsil_pkg::BSIL_I_READ)
            chain_nxt = {pin_s2_r.latch_enable_pin,
                         pin_s2_r.out_enable_n_pin,
                         din, core_q};
        end
        bsil_pkg::BSIL_P_CONTROL:
          bcr_shift_nxt = boundary_control_reg_r;
        bsil_pkg::BSIL_P_BYPASS:
          bypass_nxt = `BSIL_BYP_CAPT;
      endcase
    end
    else if (tap.shift_dr)
    begin
      unique case (dec.path)
        bsil_pkg::BSIL_P_CHAIN:
          chain_nxt = {tdi, chain_r[17:1]};
        bsil_pkg::BSIL_P_CONTROL:
          bcr_shift_nxt = {tdi, bcr_shift_r[1]};
        bsil_pkg::BSIL_P_BYPASS:
          bypass_nxt = tdi;
      endcase
    end
    else if (tap.update_dr)
    begin
      if (dec.path == bsil_pkg::BSIL_P_CHAIN)
        shadow_nxt = chain_r;
      else if (dec.path == bsil_pkg::BSIL_P_CONTROL)
        boundary_control_reg_nxt = bcr_shift_r;
    end
    else if (toggle_active)
    begin
      chain_nxt[7:0] = ~chain_r[7:0];
      upd_mask_nxt   = 18'h000FF;
    end
    else if (run_test_instruction_active)
    begin
      // bits 17 and 16 never step
      unique case (boundary_control_reg_r)
        2'h0:
        begin
          chain_nxt[15:8] = din;
          chain_nxt[7:0]  = ~chain_r[7:0];
          upd_mask_nxt    = 18'h0FFFF;
        end
        2'h1:
        begin
          chain_nxt[15:0] = step16(chain_r[15:0]);
          upd_mask_nxt    = 18'h0FFFF;
        end
        2'h2:
        begin
          chain_nxt[15:0] = sig16;
          upd_mask_nxt    = 18'h0FF00;
        end
        2'h3:
        begin
          chain_nxt[15:8] = step8(chain_r[15:8]) ^ din;
          chain_nxt[7:0]  = step8(chain_r[7:0]);
          upd_mask_nxt    = 18'h0FFFF;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      chain_r                <= '0;
      shadow_r               <= '0;
      upd_mask_r             <= '0;
      bcr_shift_r            <= '0;
      boundary_control_reg_r <= `BSIL_BCR_RST;
      bypass_r               <= 1'h0;
    end
    else
    begin
      chain_r                <= chain_nxt;
      shadow_r               <= shadow_nxt;
      upd_mask_r             <= upd_mask_nxt;
      bcr_shift_r            <= bcr_shift_nxt;
      boundary_control_reg_r <= boundary_control_reg_nxt;
      bypass_r               <= bypass_nxt;
    end
  end

  // output stage
  logic       tdo_nxt;
  logic [7:0] q_pin_out_nxt;
  logic [7:0] q_pin_oe_nxt;
  logic [7:0] core_d_nxt;
  logic       core_le_nxt;
  logic       core_oe_n_nxt;
  logic       test_mode_nxt;

  always_comb
  begin
    unique case (dec.path)
      bsil_pkg::BSIL_P_CHAIN:   tdo_nxt = chain_r[0];
      bsil_pkg::BSIL_P_CONTROL: tdo_nxt = bcr_shift_r[0];
      bsil_pkg::BSIL_P_BYPASS:  tdo_nxt = bypass_r;
      // unused path code falls back to bypass
      default:                  tdo_nxt = bypass_r;
    endcase
    test_mode_nxt = (dec.mode == bsil_pkg::BSIL_M_TEST);
    unique case (dec.mode)
      bsil_pkg::BSIL_M_TEST:
      begin
        core_d_nxt    = shadow_r[15:8];
        core_le_nxt   = shadow_r[17];
        core_oe_n_nxt = shadow_r[16];
        q_pin_out_nxt = shadow_r[7:0];
        q_pin_oe_nxt  = {8{~shadow_r[16]}};
      end
      bsil_pkg::BSIL_M_MODIFIED:
      begin
        core_d_nxt    = din;
        core_le_nxt   = pin_s2_r.latch_enable_pin;
        core_oe_n_nxt = pin_s2_r.out_enable_n_pin;
        q_pin_out_nxt = core_q;
        q_pin_oe_nxt  = 8'h00;
      end
      bsil_pkg::BSIL_M_NORMAL:
      begin
        core_d_nxt    = din;
        core_le_nxt   = pin_s2_r.latch_enable_pin;
        core_oe_n_nxt = pin_s2_r.out_enable_n_pin;
        q_pin_out_nxt = core_q;
        q_pin_oe_nxt  = {8{~pin_s2_r.out_enable_n_pin}};
      end
      default:
      begin
        core_d_nxt    = din;
        core_le_nxt   = pin_s2_r.latch_enable_pin;
        core_oe_n_nxt = pin_s2_r.out_enable_n_pin;
        q_pin_out_nxt = core_q;
        q_pin_oe_nxt  = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      tdo_bit   <= 1'h0;
      q_pin_out <= 8'h00;
      q_pin_oe  <= 8'h00;
      core_d    <= 8'h00;
      core_le   <= 1'h0;
      core_oe_n <= 1'h1;
      test_mode <= 1'h0;
      bcr_value <= `BSIL_BCR_RST;
    end
    else
    begin
      tdo_bit   <= tdo_nxt;
      q_pin_out <= q_pin_out_nxt;
      q_pin_oe  <= q_pin_oe_nxt;
      core_d    <= core_d_nxt;
      core_le   <= core_le_nxt;
      core_oe_n <= core_oe_n_nxt;
      test_mode <= test_mode_nxt;
      bcr_value <= boundary_control_reg_nxt;
    end
  end

endmodule // bsil_core

// file: core/bsil_decode.sv
// instruction decoder: instruction register value to operation
// assumes ir holds the updated instruction from the tap controller
`timescale 1ns/1ns
`include "bsil_defs.svh"

module bsil_decode (
  input  wire logic [7:0]            ir,
  output bsil_pkg::bsil_dec_type     dec
);

  always_comb
  begin
    dec.instr = bsil_pkg::BSIL_I_BYPASS;
    dec.path  = bsil_pkg::BSIL_P_BYPASS;
    dec.mode  = bsil_pkg::BSIL_M_NORMAL;
    case (ir[6:0])
      `BSIL_OP_EXT0, `BSIL_OP_EXT1:
      begin
        dec.instr = bsil_pkg::BSIL_I_EXTEST;
        dec.path  = bsil_pkg::BSIL_P_CHAIN;
        dec.mode  = bsil_pkg::BSIL_M_TEST;
      end
      `BSIL_OP_SAMPLE:
      begin
        dec.instr = bsil_pkg::BSIL_I_SAMPLE;
        dec.path  = bsil_pkg::BSIL_P_CHAIN;
      end
      `BSIL_OP_HIGHZ:
      begin
        dec.instr = bsil_pkg::BSIL_I_HIGHZ;
        dec.mode  = bsil_pkg::BSIL_M_MODIFIED;
      end
      `BSIL_OP_CLAMP:
      begin
        dec.instr = bsil_pkg::BSIL_I_CLAMP;
        dec.mode  = bsil_pkg::BSIL_M_TEST;
      end
      `BSIL_OP_RUN_TEST_INSTRUCTION:
      begin
        dec.instr = bsil_pkg::BSIL_I_RUN_TEST_INSTRUCTION;
        dec.mode  = bsil_pkg::BSIL_M_TEST;
      end
      `BSIL_OP_READN, `BSIL_OP_READT:
      begin
        dec.instr = bsil_pkg::BSIL_I_READ;
        dec.path  = bsil_pkg::BSIL_P_CHAIN;
        if (ir[0])
          dec.mode = bsil_pkg::BSIL_M_TEST;
      end
      `BSIL_OP_CELLT:
      begin
        dec.instr = bsil_pkg::BSIL_I_CELLT;
        dec.path  = bsil_pkg::BSIL_P_CHAIN;
      end
      `BSIL_OP_TOGGLE:
      begin
        dec.instr = bsil_pkg::BSIL_I_TOGGLE;
        dec.mode  = bsil_pkg::BSIL_M_TEST;
      end
      `BSIL_OP_CSCN, `BSIL_OP_CSCT:
      begin
        dec.instr = bsil_pkg::BSIL_I_CSCAN;
        dec.path  = bsil_pkg::BSIL_P_CONTROL;
        if (ir[0])
          dec.mode = bsil_pkg::BSIL_M_TEST;
      end
      default:
      begin
        dec.instr = bsil_pkg::BSIL_I_BYPASS;
      end
    endcase
  end

endmodule // bsil_decode

// file: core/bsil_defs.svh
// constants for the boundary-scan instruction logic
// assumes one test clock domain and an external tap controller
`ifndef BSIL_DEFS_SVH
`define BSIL_DEFS_SVH

`define BSIL_CHAIN_LEN   18
`define BSIL_LE_BIT      17
`define BSIL_OE_BIT      16
`define BSIL_IN_HI       15
`define BSIL_IN_LO       8
`define BSIL_OUT_HI      7
`define BSIL_OUT_LO      0
`define BSIL_BCR_RST     2'h2
`define BSIL_BYP_CAPT    1'h0
`define BSIL_PIN_IDLE    10'h100

`define BSIL_OP_EXT0     7'h00
`define BSIL_OP_SAMPLE   7'h02
`define BSIL_OP_EXT1     7'h03
`define BSIL_OP_HIGHZ    7'h06
`define BSIL_OP_CLAMP    7'h07
`define BSIL_OP_RUN_TEST_INSTRUCTION     7'h09
`define BSIL_OP_READN    7'h0A
`define BSIL_OP_READT    7'h0B
`define BSIL_OP_CELLT    7'h0C
`define BSIL_OP_TOGGLE   7'h0D
`define BSIL_OP_CSCN     7'h0E
`define BSIL_OP_CSCT     7'h0F

`define BSIL_TAPS16      16'hD008
`define BSIL_TAPS8       8'hB8

`endif

// file: core/bsil_pkg.sv
// types for the boundary-scan instruction logic
// assumes bsil_defs.svh holds the numeric constants
package bsil_pkg;

  typedef enum logic [3:0] {
    BSIL_I_BYPASS,
    BSIL_I_EXTEST,
    BSIL_I_SAMPLE,
    BSIL_I_HIGHZ,
    BSIL_I_CLAMP,
    BSIL_I_RUN_TEST_INSTRUCTION,
    BSIL_I_READ,
    BSIL_I_CELLT,
    BSIL_I_TOGGLE,
    BSIL_I_CSCAN
  } bsil_instr_type;

  typedef enum logic [1:0] {
    BSIL_P_BYPASS,
    BSIL_P_CHAIN,
    BSIL_P_CONTROL
  } bsil_path_type;

  typedef enum logic [1:0] {
    BSIL_M_NORMAL,
    BSIL_M_TEST,
    BSIL_M_MODIFIED
  } bsil_mode_type;

  typedef struct packed {
    bsil_instr_type instr;
    bsil_path_type  path;
    bsil_mode_type  mode;
  } bsil_dec_type;

  typedef struct packed {
    logic tlr;
    logic run_idle;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
  } bsil_tap_type;

  typedef struct packed {
    logic       latch_enable_pin;
    logic       out_enable_n_pin;
    logic [7:0] data_pin;
  } bsil_pins_type;

endpackage

// file: sim/bsil_core_props.sv
// assertions on the boundary-scan core ports
// assumes one core_clk domain, nrst synchronous active low
`timescale 1ns/1ns
module bsil_core_props (
  input wire logic                   core_clk,
  input wire logic                   nrst,
  input wire logic [7:0]             ir_value,
  input wire bsil_pkg::bsil_tap_type tap,
  input wire logic                   tdo_bit,
  input wire logic [7:0]             q_pin_out,
  input wire logic [7:0]             q_pin_oe,
  input wire logic [7:0]             core_d,
  input wire logic                   core_oe_n,
  input wire logic                   test_mode,
  input wire logic [1:0]             bcr_value
);
  localparam logic [15:0] TEST_MAP  = 16'hAA89;
  localparam logic [15:0] CHAIN_MAP = 16'hDC0D;
  logic [6:0] ir_p1_r;
  logic [6:0] ir_p2_r;
  logic       steady;
  logic       low_page;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge core_clk)
  begin
    ir_p1_r <= ir_value[6:0];
    ir_p2_r <= ir_p1_r;
  end
  assign low_page = (ir_value[6:4] == 3'h0);
  assign steady = (ir_value[6:0] == ir_p1_r) && (ir_p1_r == ir_p2_r);
  rst_vals_a: assert property (disable iff (1'b0)
    !nrst |=> bcr_value == 2'h2 && !test_mode && core_oe_n && q_pin_oe == 8'h00)
    else $error("reset values wrong");
  tlr_ctl_a: assert property (tap.tlr |-> ##[1:2] bcr_value == 2'h2)
    else $error("control reg not reset by tlr");
  ctl_chg_a: assert property ($changed(bcr_value) |-> $past(tap.update_dr) ||
    $past(tap.update_dr, 2) || $past(tap.tlr) || $past(tap.tlr, 2) || !$past(nrst))
    else $error("control reg changed without update");
  mode_map_a: assert property (steady && $past(nrst) |->
    test_mode == (low_page && TEST_MAP[ir_value[3:0]]))
    else $error("test mode wrong for instruction");
  highz_a: assert property (steady && $past(nrst) && ir_value[6:0] == 7'h06 |->
    q_pin_oe == 8'h00 && !test_mode)
    else $error("outputs not floated");
  byp_capt_a: assert property (tap.capture_dr &&
    !(low_page && CHAIN_MAP[ir_value[3:0]]) |-> ##2 !tdo_bit)
    else $error("bypass did not capture zero");
  oe_follow_a: assert property (test_mode |-> q_pin_oe == {8{!core_oe_n}})
    else $error("output drive disagrees with enable cell");
  sig_hold_a: assert property (steady && $past(nrst) && ir_value[6:0] == 7'h09 &&
    bcr_value == 2'h2 && tap.run_idle && $past(tap.run_idle) |-> $stable(q_pin_out))
    else $error("outputs moved during signature");
  tog_in_a: assert property (steady && $past(nrst) && ir_value[6:0] == 7'h0D &&
    tap.run_idle && $past(tap.run_idle) && $past(tap.run_idle, 2) |=> $stable(core_d))
    else $error("core inputs moved during toggle");
endmodule // bsil_core_props

bind bsil_core bsil_core_props i_props (.core_clk(core_clk), .nrst(nrst),
  .ir_value(ir_value), .tap(tap), .tdo_bit(tdo_bit), .q_pin_out(q_pin_out),
  .q_pin_oe(q_pin_oe), .core_d(core_d), .core_oe_n(core_oe_n),
  .test_mode(test_mode), .bcr_value(bcr_value));

// file: sim/bsil_tap_model.sv
// test controller model: tap state flags, serial data and instruction
// assumes the core samples everything on rising core_clk
`timescale 1ns/1ns
module bsil_tap_model (
  input  wire logic              core_clk,
  input  wire logic              tdo_bit,
  output bsil_pkg::bsil_tap_type tap,
  output logic                   tdi,
  output logic [7:0]             ir_value
);
  initial
  begin
    tap = 5'h00;
    tdi = 1'b0;
    ir_value = 8'h01;
  end
  task automatic set_ir(input logic [7:0] v);
    ir_value <= v;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic run(input int n);
    tap <= 5'h08;
    repeat (n) @(posedge core_clk);
    tap <= 5'h00;
    @(posedge core_clk);
  endtask
  task automatic reset_tap;
    tap <= 5'h10;
    @(posedge core_clk);
    tap <= 5'h00;
    @(posedge core_clk);
  endtask
  // capture, n shifts lsb first, update; dout is what came out
  task automatic scan(input int n, input logic [17:0] din, output logic [17:0] dout);
    dout = 18'h00000;
    tap <= 5'h04;
    @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      tap <= 5'h02;
      tdi <= din[i];
      @(posedge core_clk);
      if (i > 0)
        dout[i-1] = tdo_bit;
    end
    tap <= 5'h01;
    @(posedge core_clk);
    dout[n-1] = tdo_bit;
    tap <= 5'h00;
    tdi <= ~tdi;
    @(posedge core_clk);
  endtask
endmodule // bsil_tap_model

// file: sim/tb.sv
// self-checking bench for the boundary-scan core
// assumes bsil_tap_model plays the test controller
`timescale 1ns/1ns
`include "bsil_defs.svh"
module tb;
  logic                    core_clk;
  logic                    nrst;
  bsil_pkg::bsil_tap_type  tap;
  bsil_pkg::bsil_pins_type pins;
  logic                    tdi;
  logic                    tdo_bit;
  logic [7:0]              ir_value;
  logic [7:0]              core_q;
  logic [7:0]              q_pin_out;
  logic [7:0]              q_pin_oe;
  logic [7:0]              core_d;
  logic                    core_le;
  logic                    core_oe_n;
  logic                    test_mode;
  logic [1:0]              bcr_value;
  logic [17:0]             dout;
  int                      err_count;
  int                      tests_run;

  bsil_core i_dut (.core_clk(core_clk), .nrst(nrst), .ir_value(ir_value), .tap(tap),
    .tdi(tdi), .pins(pins), .core_q(core_q), .tdo_bit(tdo_bit), .q_pin_out(q_pin_out),
    .q_pin_oe(q_pin_oe), .core_d(core_d), .core_le(core_le), .core_oe_n(core_oe_n),
    .test_mode(test_mode), .bcr_value(bcr_value));
  bsil_tap_model i_tap (.core_clk(core_clk), .tdo_bit(tdo_bit), .tap(tap), .tdi(tdi),
    .ir_value(ir_value));

  always #25 core_clk = ~core_clk;

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic t_modes;
    logic [15:0] tm;
    tm = 16'hAA89;
    for (int i = 0; i < 256; i++)
    begin
      i_tap.set_ir(i[7:0]);
      step(1);
      chk(test_mode === (i[6:4] == 3'h0 && tm[i[3:0]]), "mode");
      if (i[6:0] == 7'h06) chk(q_pin_oe === 8'h00, "float");
    end
  endtask
  task automatic t_bypass;
    logic [7:0] codes [6] = '{8'h01, 8'h06, 8'h07, 8'h09, 8'h0D, 8'h35};
    foreach (codes[k])
    begin
      i_tap.set_ir(codes[k]);
      i_tap.scan(2, 18'h00003, dout);
      chk(dout[1:0] === 2'h2, "bypass path");
    end
  endtask
  task automatic t_ctl;
    logic [1:0] prev;
    prev = 2'h2;
    for (int v = 0; v < 4; v++)
    begin
      i_tap.set_ir(v[0] ? 8'h0F : 8'h0E);
      i_tap.scan(2, 18'(v), dout);
      step(2);
      chk(dout[1:0] === prev && bcr_value === v[1:0], "control scan");
      prev = v[1:0];
    end
    i_tap.reset_tap();
    step(1);
    chk(bcr_value === 2'h2, "tlr");
  endtask
  task automatic t_chain;
    pins <= '{1'b1, 1'b0, 8'hA5};
    core_q <= 8'h3C;
    i_tap.set_ir(8'h02);
    step(2);
    i_tap.scan(18, 18'h05AC3, dout);
    chk(dout === 18'h2A53C && test_mode === 1'b0, "sample");
    i_tap.set_ir(8'h00);
    step(1);
    chk(q_pin_out === 8'hC3 && q_pin_oe === 8'hFF && core_d === 8'h5A, "extest");
    i_tap.set_ir(8'h07);
    chk(q_pin_out === 8'hC3 && core_d === 8'h5A && test_mode === 1'b1, "clamp");
    i_tap.set_ir(8'h0A);
    i_tap.scan(18, 18'h05AC3, dout);
    chk(dout === 18'h05AC3, "read");
    i_tap.set_ir(8'h0C);
    i_tap.scan(18, 18'h05AC3, dout);
    chk(dout === 18'h3A53C, "self test");
  endtask
  task automatic t_run;
    logic [15:0] sg;
    i_tap.set_ir(8'h0E);
    i_tap.scan(2, 18'h00000, dout);
    i_tap.set_ir(8'h09);
    i_tap.run(1);
    step(2);
    chk(q_pin_out === 8'h3C && core_d === 8'hA5 && test_mode === 1'b1, "toggle op");
    pins <= '{1'b1, 1'b0, 8'h11};
    i_tap.set_ir(8'h0D);
    i_tap.run(3);
    step(2);
    chk(q_pin_out === 8'hC3 && core_d === 8'hA5 && core_le === 1'b0, "toggle");
    i_tap.set_ir(8'h0E);
    i_tap.scan(2, 18'h00002, dout);
    i_tap.set_ir(8'h09);
    i_tap.run(4);
    step(2);
    chk(q_pin_out === 8'hC3 && q_pin_oe === 8'hFF, "signature");
    sg = 16'hA5C3;
    for (int s = 0; s < 4; s++)
      sg = {sg[14:0], ^(sg & `BSIL_TAPS16)} ^ 16'h1100;
    i_tap.set_ir(8'h0A);
    i_tap.scan(18, 18'h00000, dout);
    chk(dout === {2'h0, sg}, "signature read");
  endtask
  task automatic t_pattern_generation(input logic [15:0] seed);
    logic [15:0] nx;
    nx = {seed[14:0], ^(seed & `BSIL_TAPS16)};
    i_tap.set_ir(8'h0E);
    i_tap.scan(2, 18'h00001, dout);
    i_tap.set_ir(8'h00);
    i_tap.scan(18, {2'h0, seed}, dout);
    i_tap.set_ir(8'h09);
    i_tap.run(1);
    step(2);
    chk(q_pin_out === nx[7:0] && core_d === nx[15:8], "pattern");
  endtask
  task automatic t_normal;
    for (int k = 0; k < 8; k++)
    begin
      i_tap.set_ir(k[2] ? 8'h86 : 8'h01);
      pins <= '{k[0], k[1], 8'h01 << k};
      core_q <= 8'h80 >> k;
      step(4);
      chk(core_d === (8'h01 << k) && core_le === k[0] && core_oe_n === k[1], "core in");
      chk(q_pin_out === (8'h80 >> k) && test_mode === 1'b0, "pin out");
      chk(q_pin_oe === (k[2] ? 8'h00 : {8{!k[1]}}), "pin drive");
    end
  endtask
  task automatic t_mix(input logic [15:0] seed, input logic [7:0] d);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = {seed[14:8], ^(seed[15:8] & `BSIL_TAPS8)} ^ d;
    lo = {seed[6:0], ^(seed[7:0] & `BSIL_TAPS8)};
    pins <= '{1'b0, 1'b0, d};
    i_tap.set_ir(8'h0F);
    i_tap.scan(2, 18'h00003, dout);
    i_tap.set_ir(8'h03);
    i_tap.scan(18, {2'h0, seed}, dout);
    i_tap.set_ir(8'h09);
    i_tap.run(1);
    step(2);
    chk(q_pin_out === lo && core_d === hi, "combined");
    i_tap.set_ir(8'h0B);
    i_tap.scan(18, 18'h00000, dout);
    chk(dout === {2'h0, hi, lo}, "combined read");
  endtask

  initial
  begin
    core_clk = 1'b0;
    nrst = 1'b0;
    pins = '{1'b0, 1'b1, 8'h00};
    core_q = 8'h00;
    err_count = 0;
    tests_run = 0;
    step(4);
    nrst <= 1'b1;
    step(2);
    chk(bcr_value === 2'h2 && test_mode === 1'b0 && core_oe_n === 1'b1, "reset");
    t_modes();
    t_bypass();
    t_ctl();
    t_chain();
    t_run();
    t_pattern_generation(16'h0000);
    t_pattern_generation(16'h5AC3);
    t_normal();
    t_mix(16'h0000, 8'h00);
    t_mix(16'hA5C3, 8'h5A);
    tally_and_finish();
  end

  initial
  begin
    step(5000);
    err_count++;
    tally_and_finish();
  end
endmodule // tb
